// file: bench/bank_close_properties.sv
// checker for bank close timing at the top ports
// assumes no command before the third edge after reset release
`timescale 1ns/1ps
module bank_close_properties #(
  parameter NB = 8
) (
  // clock, reset, command bus
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire cs_n_in,
  input wire [9:0] ca_rise_in,
  input wire [9:0] ca_fall_in,
  input wire wdata_word_in,
  // status
  input wire [NB-1:0] bank_open_out,
  input wire [NB-1:0] bank_closing_out,
  input wire [NB-1:0] auto_pending_out,
  input wire [NB-1:0] close_start_out,
  input wire array_write_out,
  input wire illegal_cmd_out
);
  wire c = !cs_n_in;
  wire [2:0] b = ca_rise_in[9:7];
  wire rd = c && ca_rise_in[2:0] == 3'h5;
  wire wr = c && ca_rise_in[2:0] == 3'h1;
  wire pre = c && ca_rise_in[3:0] == 4'hB;
  wire ap = ca_fall_in[0];
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  a_rd_close_time: assert property (rd && ap |-> ##3 close_start_out[$past(b, 3)])
    else $error("read close start off time");
  a_wr_close_time: assert property (wr && ap |-> ##6 close_start_out[$past(b, 6)])
    else $error("write close start off time");
  a_pend_armed: assert property ((rd || wr) && ap |=> auto_pending_out[$past(b)])
    else $error("auto close not armed");
  a_open_kept: assert property (rd && !ap && !auto_pending_out[b] |=> !auto_pending_out[$past(b)])
    else $error("auto close armed with flag low");
  a_pre_one_bank: assert property (pre && !ca_rise_in[4] |=> bank_closing_out[$past(b)])
    else $error("single precharge missed");
  a_pre_all_banks: assert property (pre && ca_rise_in[4] |=> &bank_closing_out)
    else $error("all bank precharge missed");
  a_start_one_cycle: assert property (|close_start_out && !pre |=>
    !(|(close_start_out & $past(close_start_out))))
    else $error("close start too long");
  a_pend_access: assert property ((rd || wr) && auto_pending_out[b] |=> illegal_cmd_out)
    else $error("access to pending bank unflagged");
  a_cut_pending: assert property (c && ca_rise_in[3:0] == 4'h3 && |auto_pending_out |=> illegal_cmd_out)
    else $error("cut of auto close unflagged");
  c_rd_ap: cover property (rd && ap);
  c_wr_ap: cover property (wr && ap);
  c_bad: cover property (illegal_cmd_out);
endmodule // bank_close_properties
bind bank_close_ctrl bank_close_properties #(.NB(NB)) chk (.clk_sys_in, .arst_n_in, .cs_n_in,
  .ca_rise_in, .ca_fall_in, .wdata_word_in, .bank_open_out, .bank_closing_out,
  .auto_pending_out, .close_start_out, .array_write_out, .illegal_cmd_out);

// file: bench/mem_ctrl_model.sv
// controller model driving the command bus
// assumes the bench spaces commands as the controller must
`timescale 1ns/1ps
module mem_ctrl_model (
  // clock
  input wire clk_sys_in,
  // command bus
  output logic cs_n_out = 1'b1,
  output logic [9:0] ca_r_out = 10'h000,
  output logic [9:0] ca_f_out = 10'h000,
  output logic word_out = 1'b0
);
  // one command, then the bus shows the inverse
  task send(input [3:0] op, input [2:0] ba, input ap, input ab);
    @(posedge clk_sys_in);
    cs_n_out <= 1'b0;
    ca_r_out <= {ba, 2'h0, ab, op};
    ca_f_out <= {9'h000, ap};
    @(posedge clk_sys_in);
    cs_n_out <= 1'b1;
    ca_r_out <= ~ca_r_out;
    ca_f_out <= ~ca_f_out;
  endtask
  task words(input int n);
    @(posedge clk_sys_in);
    word_out <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    word_out <= 1'b0;
  endtask
endmodule // mem_ctrl_model

// file: bench/tb_dram_precharge_autoprecharge_timing.sv
// bench for bank close timing
// assumes the controller model drives all command inputs
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_dram_precharge_autoprecharge_timing;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  int fails = 0;
  int check_count = 0;
  wire cs_n, word, aw, bad;
  wire [9:0] ca_r, ca_f;
  wire [7:0] op, cl, pend, st;
  mem_ctrl_model mc (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n), .ca_r_out(ca_r),
    .ca_f_out(ca_f), .word_out(word));
  bank_close_ctrl dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .cs_n_in(cs_n),
    .ca_rise_in(ca_r), .ca_fall_in(ca_f), .wdata_word_in(word), .bank_open_out(op),
    .bank_closing_out(cl), .auto_pending_out(pend), .close_start_out(st),
    .array_write_out(aw), .illegal_cmd_out(bad));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    fails++;
    wrap_up;
  end
  //////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task t_read_ap;
    mc.send(4'h2, 3'd3, 1'b0, 1'b0);
    mc.send(4'h2, 3'd4, 1'b0, 1'b0);
    mc.send(4'h5, 3'd3, 1'b1, 1'b0);
    mc.send(4'h5, 3'd4, 1'b1, 1'b0);
    cyc(0);
    `CHK("rd close b3", 8'h08, st)
    cyc(2);
    `CHK("rd close b4", 8'h10, st)
    mc.send(4'h2, 3'd3, 1'b0, 1'b0);
    cyc(0);
    `CHK("rd reopen", 1'b1, op[3])
  endtask
  task t_write_ap;
    logic [7:0] early, late;
    early = 8'h00;
    late = 8'h00;
    mc.send(4'h2, 3'd2, 1'b0, 1'b0);
    mc.send(4'h1, 3'd2, 1'b1, 1'b0);
    for (int i = 1; i < 9; i++) begin
      cyc(1);
      if (i == 1) `CHK("wr pend", 8'h04, pend)
      if (i < 5) early |= st; else late |= st;
    end
    `CHK("wr early", 8'h00, early)
    `CHK("wr close", 8'h04, late)
    `CHK("wr shut", 1'b0, op[2])
    mc.send(4'h2, 3'd2, 1'b0, 1'b0);
    cyc(0);
    `CHK("wr reopen", 1'b1, op[2])
  endtask
  task t_illegal;
    mc.send(4'h2, 3'd1, 1'b0, 1'b0);
    mc.send(4'h1, 3'd1, 1'b1, 1'b0);
    mc.send(4'h5, 3'd1, 1'b0, 1'b0);
    cyc(0);
    `CHK("rd pend bank", 1'b1, bad)
    mc.send(4'h3, 3'd0, 1'b0, 1'b0);
    cyc(0);
    `CHK("cut pend", 1'b1, bad)
    cyc(8);
  endtask
  task t_read_noap;
    mc.send(4'h2, 3'd6, 1'b0, 1'b0);
    mc.send(4'h5, 3'd6, 1'b0, 1'b0);
    cyc(4);
    `CHK("no pend", 8'h00, pend)
    `CHK("stays open", 1'b1, op[6])
  endtask
  task t_precharge;
    mc.send(4'hB, 3'd6, 1'b0, 1'b0);
    cyc(0);
    `CHK("pre one", 8'h40, cl)
    mc.send(4'hB, 3'd0, 1'b0, 1'b1);
    cyc(0);
    `CHK("pre all", 8'hFF, cl)
    `CHK("all shut", 8'h00, op)
    cyc(2);
    `CHK("pre done", 8'h00, cl)
  endtask
  task t_cut_pre;
    mc.send(4'h2, 3'd7, 1'b0, 1'b0);
    mc.send(4'h1, 3'd7, 1'b0, 1'b0);
    mc.send(4'h3, 3'd7, 1'b0, 1'b0);
    cyc(0);
    `CHK("cut legal", 1'b0, bad)
    cyc(2); // gap counted per bank
    mc.send(4'hB, 3'd7, 1'b0, 1'b0);
    cyc(0);
    `CHK("pre after cut", 8'h80, cl)
    `CHK("shut after cut", 1'b0, op[7])
  endtask
  task t_words(input int n, input logic [3:0] e);
    logic [3:0] k;
    k = 4'h0;
    fork
      mc.words(n);
      repeat (n + 3) begin
        cyc(1);
        k = k + aw;
      end
    join
    `CHK("array writes", e, k)
  endtask
  task wrap_up;
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    cyc(3);
    t_read_ap;
    t_write_ap;
    t_illegal;
    t_read_noap;
    t_precharge;
    t_cut_pre;
    t_words(4, 4'h1);
    t_words(3, 4'h0);
    t_words(1, 4'h1);
    wrap_up;
  end
endmodule // tb_dram_precharge_autoprecharge_timing

// file: verilog/bank_close_ctrl.v
// device-side bank closing: precharge decode, auto-close timing
// assumes CA sampled at rise (ca_rise) and fall (ca_fall) by the pad logic
//
// Function
// - write data reaches the array in whole groups of four words.
// - auto-close flag taken from CA0 at falling edge of read/write.
// - read auto-close starts at max(BL/2, BL/2-2+RU(tRTP/tCK)).
// - write auto-close starts tWR cycles after the write burst ends.
// - seamless other-bank reads or writes every BL/2 are supported.
// - precharge period timed from latest precharge hitting the bank.
// - precharge is CS low with CA3..0 = 1,0,1,1 at rise.
// - all-bank flag closes every bank, else three bits select one.
`timescale 1ns/1ps
`include "bank_close_defines.vh"
module bank_close_ctrl #(
  parameter WL = `WL_DEF,
  parameter BL = `BL_DEF,
  parameter NB = `NUM_BANKS,
  parameter CNT_W = `CNT_W
) (
  // clock and reset
  input wire clk_sys_in,
  input wire arst_n_in,
  // command bus
  input wire cs_n_in,
  input wire [`CA_W-1:0] ca_rise_in,
  input wire [`CA_W-1:0] ca_fall_in,
  // write data words as latched
  input wire wdata_word_in,
  // bank status
  output wire [NB-1:0] bank_open_out,
  output wire [NB-1:0] bank_closing_out,
  output wire [NB-1:0] auto_pending_out,
  output reg [NB-1:0] close_start_out,
  output reg array_write_out,
  output reg illegal_cmd_out
);
  ////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_s1_q;
  reg rst_n_q;
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // derived delays
  localparam integer HALF_BL = BL / 2;
  localparam integer RTP_C = `RTP_CYC;
  localparam integer RTP_M = (RTP_C > 2) ? RTP_C : 2;
  // cycles from command to start, minus one for the countdown register
  localparam integer RD_AP_N = HALF_BL - 2 + RTP_M - 1;
  localparam integer WR_AP_N = WL + HALF_BL + 1 + `WR_CYC - 1;
  localparam integer RP_PB_N = `RPPB_CYC;
  localparam integer RP_AB_N = `RPAB_CYC;
  localparam [CNT_W-1:0] RD_AP_DLY = RD_AP_N[CNT_W-1:0];
  localparam [CNT_W-1:0] WR_AP_DLY = WR_AP_N[CNT_W-1:0];
  localparam [CNT_W-1:0] RP_PB = RP_PB_N[CNT_W-1:0];
  localparam [CNT_W-1:0] RP_AB = RP_AB_N[CNT_W-1:0];
  function [NB-1:0] bank_dec;
    input [2:0] ba;
    begin
      bank_dec = {{(NB-1){1'b0}}, 1'b1} << ba;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // command decode
  wire cmd_act = !cs_n_in && !ca_rise_in[0] && ca_rise_in[1];
  wire cmd_rd = !cs_n_in && ca_rise_in[0] && !ca_rise_in[1] && ca_rise_in[2];
  wire cmd_wr = !cs_n_in && ca_rise_in[0] && !ca_rise_in[1] && !ca_rise_in[2];
  wire cmd_pre = !cs_n_in && (ca_rise_in[3:0] == 4'hB);
  wire cmd_cut = !cs_n_in && (ca_rise_in[3:0] == 4'h3);
  wire [2:0] ba = ca_rise_in[`CA_BA_LSB+2:`CA_BA_LSB];
  wire auto_close_flag = ca_fall_in[`CA_AP_BIT];
  wire all_bank_flag = ca_rise_in[`CA_AB_BIT];
  wire [NB-1:0] sel = bank_dec(ba);
  wire [NB-1:0] pre_hit = all_bank_flag ? {NB{1'b1}} : sel;
  wire [CNT_W-1:0] rp_len = all_bank_flag ? RP_AB : RP_PB;
  wire [NB-1:0] start_w;
  ////////////////////////////////////////////////////////////////////////
  // per-bank timers, independent so other banks run back to back
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_bank
      wire hit = sel[g];
      wire arm = hit && auto_close_flag && (cmd_rd || cmd_wr) && rst_n_q;
      bank_timer #(
        .CNT_W(CNT_W)
      ) u_timer (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_q),
        .arm_in(arm),
        .arm_delay_in(cmd_rd ? RD_AP_DLY : WR_AP_DLY),
        .close_in(cmd_pre && pre_hit[g]),
        .close_len_in(cmd_pre ? rp_len : RP_PB),
        .open_out(bank_open_out[g]),
        .auto_pending_out(auto_pending_out[g]),
        .closing_out(bank_closing_out[g]),
        .close_start_out(start_w[g]),
        .activate_in(cmd_act && hit)
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // close-start strobe, illegal flag
  wire same_bank_busy = |(sel & auto_pending_out);
  always @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      close_start_out <= {NB{1'b0}};
      illegal_cmd_out <= 1'b0;
    end else begin
      close_start_out <= start_w;
      // read/write into a pending auto-close bank, or cut while any bank has one pending
      illegal_cmd_out <= ((cmd_rd || cmd_wr) && same_bank_busy)
                         || (cmd_cut && (|auto_pending_out));
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // prefetch grouping of write words
  reg [1:0] word_cnt_q;
  always @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      word_cnt_q <= 2'h0;
      array_write_out <= 1'b0;
    end else begin
      array_write_out <= 1'b0;
      if (wdata_word_in) begin
        word_cnt_q <= word_cnt_q + 2'h1;
        if (word_cnt_q == 2'h3)
          array_write_out <= 1'b1;
      end
    end
  end
endmodule // bank_close_ctrl

// file: verilog/bank_close_defines.vh
// constants for the bank-closing timing block
// assumes a 40 MHz system clock
`ifndef BANK_CLOSE_DEFINES_VH
`define BANK_CLOSE_DEFINES_VH
`define CLK_PERIOD_PS 25000
`define T_RTP_PS 7500
`define T_WR_PS 15000
`define T_RPPB_PS 18000
`define T_RPAB_PS 21000
`define RTP_CYC ((`T_RTP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WR_CYC ((`T_WR_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RPPB_CYC ((`T_RPPB_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RPAB_CYC ((`T_RPAB_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WL_DEF 1
`define BL_DEF 4
`define PREFETCH_WORDS 4
`define NUM_BANKS 8
`define CA_W 10
`define CA_AP_BIT 0
`define CA_AB_BIT 4
`define CA_BA_LSB 7
`define CNT_W 8
`endif

// file: verilog/bank_timer.v
// one bank: auto-close countdown and precharge period countdown
// assumes command pulses from the decoder on the same clock
`timescale 1ns/1ps
module bank_timer #(
  parameter CNT_W = 8
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // requests
  input wire arm_in,
  input wire [CNT_W-1:0] arm_delay_in,
  input wire close_in,
  input wire [CNT_W-1:0] close_len_in,
  // status, and the activate request
  output reg open_out,
  output wire auto_pending_out,
  output wire closing_out,
  output wire close_start_out,
  input wire activate_in
);
  reg [CNT_W-1:0] ap_cnt_q;
  reg ap_pend_q;
  reg [CNT_W-1:0] rp_cnt_q;
  wire ap_fire;
  assign ap_fire = ap_pend_q && (ap_cnt_q == {CNT_W{1'b0}});
  assign close_start_out = ap_fire || close_in;
  assign auto_pending_out = ap_pend_q;
  assign closing_out = (rp_cnt_q != {CNT_W{1'b0}});
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ap_cnt_q <= {CNT_W{1'b0}};
      ap_pend_q <= 1'b0;
      rp_cnt_q <= {CNT_W{1'b0}};
      open_out <= 1'b0;
    end else begin
      if (arm_in) begin
        ap_pend_q <= 1'b1;
        ap_cnt_q <= arm_delay_in;
      end else if (ap_fire) begin
        ap_pend_q <= 1'b0;
      end else if (ap_pend_q) begin
        ap_cnt_q <= ap_cnt_q - 1'b1;
      end
      // latest precharge restarts the period
      if (close_in)
        rp_cnt_q <= close_len_in;
      else if (ap_fire)
        rp_cnt_q <= close_len_in;
      else if (rp_cnt_q != {CNT_W{1'b0}})
        rp_cnt_q <= rp_cnt_q - 1'b1;
      if (close_start_out)
        open_out <= 1'b0;
      else if (activate_in)
        open_out <= 1'b1;
    end
  end
endmodule // bank_timer
